// ---- shared/cam_regs.vh ----
// register map, field positions and reset values of the counter mode block
`ifndef CAM_REGS_VH
`define CAM_REGS_VH
// register index 0xD9 is not a multiple of four: byte address = 4 * index
`define CAM_MODE_IDX 12'h0D9
`define CAM_MODE_ADDR 12'h364
`define CAM_CTRL_ADDR 12'h368
`define CAM_COUNT_ADDR 12'h36C
`define CAM_IDLE_BIT 7
`define CAM_WDT_BIT 6
`define CAM_RSV_HI 5
`define CAM_RSV_LO 3
`define CAM_SRC_HI 2
`define CAM_SRC_LO 1
`define CAM_IRQEN_BIT 0
`define CAM_CTRL_RUN_BIT 0
`define CAM_CTRL_IDLE_BIT 1
`define CAM_CTRL_FLAG_BIT 7
`define CAM_SRC_DIV6 2'h0
`define CAM_SRC_DIV2 2'h1
`define CAM_SRC_TMR0 2'h2
`define CAM_SRC_EXT 2'h3
`define CAM_DIV6_LAST 3'h5
`define CAM_DIV2_LAST 3'h1
`define CAM_MODE_RESET 8'h00
`define CAM_COUNT_RESET 16'h0000
`endif

// ---- logic/cam_prescale.v ----
// divided tick generator for the counter array clock
`include "cam_regs.vh"
`default_nettype none
module cam_prescale (
   input wire core_clk_i, // 125 MHz clock
   input wire rst_b_i, // synchronous reset, active low
   input wire [2:0] last_i, // terminal count (divide minus one)
   output reg tick_o // one-cycle tick every last_i+1 clocks
);
   reg [2:0] cnt_reg;
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         cnt_reg <= 3'h0;
         tick_o <= 1'b0;
      end else if (cnt_reg >= last_i) begin
         cnt_reg <= 3'h0;
         tick_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
         tick_o <= 1'b0;
      end
   end
endmodule // cam_prescale
`default_nettype wire

// ---- logic/cam_edge_det.v ----
// rising-edge detector for the external count input
`include "cam_regs.vh"
`default_nettype none
module cam_edge_det (
   input wire core_clk_i, // 125 MHz clock
   input wire rst_b_i, // synchronous reset, active low
   input wire level_i, // sampled level, synchronous to clock
   output wire rise_o // one-cycle pulse on a rising edge
);
   reg prev_reg;
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= level_i;
      end
   end
   assign rise_o = level_i & ~prev_reg;
endmodule // cam_edge_det
`default_nettype wire

// ---- logic/cam_mode_ctrl.v ----
// counter array mode register with APB slave, source select and counter
//
// Notes on behaviour
// - mode bit 7 set stops the counter while idle mode is active; clear lets it run.
// - mode bit 6 enables the watchdog function of counter module 4 when set.
// - the source field picks clock/6 (00), clock/2 (01), timer 0 overflow (10) or the external pin (11).
// - mode bit 0 lets the overflow flag raise the interrupt; clear blocks it.
// - reset clears idle select, watchdog enable, source and interrupt enable.
//
// Register access over APB was chosen for this implementation.
`include "cam_regs.vh"
`default_nettype none
module cam_mode_ctrl #(
   parameter CNT_W = 16 // counter width
) (
   input wire core_clk_i, // 125 MHz clock
   input wire rst_b_i, // synchronous reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   input wire [3:0] pstrb, // apb byte strobes
   output wire pready, // apb ready, always one
   output reg [31:0] prdata, // apb read data
   output wire pslverr, // apb error on unmapped address
   input wire idle_mode_i, // device idle mode level
   input wire timer0_ovf_i, // timer 0 overflow pulse
   input wire ext_count_i, // external count input level
   output reg module_watchdog_enable_o, // watchdog on module 4
   output reg counter_run_o, // counter is advancing
   output reg [CNT_W-1:0] count_o, // current count
   output reg counter_overflow_flag_o, // sticky overflow flag
   output reg irq_o // overflow interrupt request
);
   ////////////////////////////////////////////////////////////////////
   // apb decode
   wire hit_mode = (paddr == `CAM_MODE_ADDR);
   wire hit_ctrl = (paddr == `CAM_CTRL_ADDR);
   wire hit_cnt = (paddr == `CAM_COUNT_ADDR);
   wire mapped = hit_mode | hit_ctrl | hit_cnt;
   wire acc = psel & penable;
   wire wr_en = acc & pwrite & pstrb[0];
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   ////////////////////////////////////////////////////////////////////
   // mode and control registers
   reg idle_halt_select_reg;
   reg [1:0] count_source_sel_reg;
   reg overflow_irq_enable_reg;
   reg run_enable_reg;
   reg ovf_pulse;
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         idle_halt_select_reg <= 1'b0;
         module_watchdog_enable_o <= 1'b0;
         count_source_sel_reg <= `CAM_SRC_DIV6;
         overflow_irq_enable_reg <= 1'b0;
         run_enable_reg <= 1'b0;
      end else if (wr_en && hit_mode) begin
         // reserved bits 5..3 are not stored; writing ones has no effect
         idle_halt_select_reg <= pwdata[`CAM_IDLE_BIT];
         module_watchdog_enable_o <= pwdata[`CAM_WDT_BIT];
         count_source_sel_reg <= pwdata[`CAM_SRC_HI:`CAM_SRC_LO];
         overflow_irq_enable_reg <= pwdata[`CAM_IRQEN_BIT];
      end else if (wr_en && hit_ctrl) begin
         run_enable_reg <= pwdata[`CAM_CTRL_RUN_BIT];
      end
   end

   // overflow flag: hardware set beats a software clear in the same cycle
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         counter_overflow_flag_o <= 1'b0;
      end else if (ovf_pulse) begin
         counter_overflow_flag_o <= 1'b1;
      end else if (wr_en && hit_ctrl && !pwdata[`CAM_CTRL_FLAG_BIT]) begin
         counter_overflow_flag_o <= 1'b0;
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= counter_overflow_flag_o & overflow_irq_enable_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // count pulse sources
   wire tick_div6;
   wire tick_div2;
   wire ext_rise;
   cam_prescale u_div6 (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .last_i(`CAM_DIV6_LAST),
      .tick_o(tick_div6)
   );
   cam_prescale u_div2 (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .last_i(`CAM_DIV2_LAST),
      .tick_o(tick_div2)
   );
   // edge detection at the clock rate is only reliable when the pin
   // toggles no faster than a quarter of the array clock
   cam_edge_det u_ext (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .level_i(ext_count_i),
      .rise_o(ext_rise)
   );

   reg count_pulse;
   always @* begin
      case (count_source_sel_reg)
         `CAM_SRC_DIV6: count_pulse = tick_div6;
         `CAM_SRC_DIV2: count_pulse = tick_div2;
         `CAM_SRC_TMR0: count_pulse = timer0_ovf_i;
         default: count_pulse = ext_rise;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // counter
   wire halted = idle_halt_select_reg & idle_mode_i;
   wire advance = run_enable_reg & ~halted & count_pulse;
   always @* begin
      ovf_pulse = advance & (&count_o);
   end

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         count_o <= `CAM_COUNT_RESET;
         counter_run_o <= 1'b0;
      end else begin
         counter_run_o <= run_enable_reg & ~halted;
         if (wr_en && hit_cnt) begin
            count_o <= pwdata[CNT_W-1:0];
         end else if (advance) begin
            // while halted the count simply holds and resumes in place
            count_o <= count_o + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (hit_mode) begin
            prdata <= {24'h000000, idle_halt_select_reg,
                       module_watchdog_enable_o, 3'h0,
                       count_source_sel_reg, overflow_irq_enable_reg};
         end else if (hit_ctrl) begin
            prdata <= {24'h000000, counter_overflow_flag_o, 5'h00,
                       idle_mode_i, run_enable_reg};
         end else if (hit_cnt) begin
            prdata <= {{(32-CNT_W){1'b0}}, count_o};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end
endmodule // cam_mode_ctrl
`default_nettype wire

// ---- dv/cam_mode_chk.sv ----
// assertions on the ports of the counter mode block
`include "cam_regs.vh"
`default_nettype none
module cam_mode_chk #(
   parameter CNT_W = 16 // counter width
) (
   input wire logic core_clk_i, // clock
   input wire logic rst_b_i, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb data
   input wire logic [3:0] pstrb, // apb strobes
   input wire logic pslverr, // apb error
   input wire logic idle_mode_i, // idle level
   input wire logic module_watchdog_enable_o, // watchdog on
   input wire logic counter_run_o, // counting
   input wire logic [CNT_W-1:0] count_o, // count
   input wire logic counter_overflow_flag_o, // overflow
   input wire logic irq_o // interrupt
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire logic wr = psel && penable && pwrite && pstrb[0];
   wire logic wr_mode = wr && paddr == `CAM_MODE_ADDR;
   ////////////////////////////////////////////////////////////////////////
   property p_rst;
      $rose(rst_b_i) |-> !module_watchdog_enable_o && !irq_o && count_o == 0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear");
   // the watchdog enable is the mode flop itself: visible one edge later
   property p_wdt;
      wr_mode |-> ##1 module_watchdog_enable_o == $past(pwdata[`CAM_WDT_BIT]);
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog bit");
   property p_irq; irq_o |-> $past(counter_overflow_flag_o); endproperty
   a_irq: assert property (p_irq) else $error("irq without flag");
   property p_hold;
      (!counter_run_o && idle_mode_i && !wr)[*3] |=> $stable(count_o);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_err; psel && penable && paddr < 12'h364 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no slave error");
   // the flag and the wrap land on the same edge
   property p_ovf;
      $rose(counter_overflow_flag_o) |->
         count_o == 16'h0000 && $past(count_o) == 16'hFFFF;
   endproperty
   a_ovf: assert property (p_ovf) else $error("flag without wrap");
   c_irq: cover property ($rose(irq_o));
   c_halt: cover property (!counter_run_o && idle_mode_i);
   c_wdt: cover property ($rose(module_watchdog_enable_o));
endmodule // cam_mode_chk
bind cam_mode_ctrl cam_mode_chk #(.CNT_W(CNT_W)) u_chk (.core_clk_i,
   .rst_b_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr,
   .idle_mode_i, .module_watchdog_enable_o, .counter_run_o, .count_o,
   .counter_overflow_flag_o, .irq_o);
`default_nettype wire

// ---- dv/test_counter_array_mode_control.sv ----
// self-checking bench for the counter mode block
`include "cam_regs.vh"
`default_nettype none
module test_counter_array_mode_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic idle_mode_i = 0, timer0_ovf_i = 0, ext_count_i = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, m;
   logic [3:0] pstrb = 4'hF;
   wire pready, pslverr, module_watchdog_enable_o, counter_run_o;
   wire counter_overflow_flag_o, irq_o;
   wire [31:0] prdata;
   wire [15:0] count_o;
   int num_errors = 0, checks = 0, d;
   cam_mode_ctrl dut (.core_clk_i, .rst_b_i, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .idle_mode_i,
      .timer0_ovf_i, .ext_count_i, .module_watchdog_enable_o,
      .counter_run_o, .count_o, .counter_overflow_flag_o, .irq_o);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // bounded wait: a slave that never answers ends the run
   task automatic apb(input logic w, input logic [11:0] a, logic [31:0] wd);
      int n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk_i) penable <= 1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk_i);
   endtask
   // ext pin: 2 high, 4 low, below a quarter of the clock rate
   task automatic tick(input int n, input logic ext);
      repeat (n) begin
         if (ext) ext_count_i <= 1;
         else timer0_ovf_i <= 1;
         @(posedge core_clk_i) timer0_ovf_i <= 0;
         @(posedge core_clk_i) ext_count_i <= 0;
         repeat (4) @(posedge core_clk_i);
      end
   endtask
   function automatic int span(input int s);
      return s == 0 ? 26 / 6 : s == 1 ? 26 / 2 : 5;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial forever #4 core_clk_i = ~core_clk_i;
   initial begin
      void'($urandom(39));
      repeat (4) @(posedge core_clk_i);
      rst_b_i <= 1;
      @(posedge core_clk_i);
      apb(0, `CAM_MODE_ADDR, 0);
      check("mode", rd & 32'hC7, 0);
      repeat (6) begin
         m = $urandom & 32'hC7; // reserved bits stay zero
         apb(1, `CAM_MODE_ADDR, m);
         apb(0, `CAM_MODE_ADDR, 0);
         check("mode", rd & 32'hC7, m);
         check("wdt", module_watchdog_enable_o, m[6]);
      end
      apb(0, 12'h000, 0);
      check("slverr", err, 1);
      $display("register test done");
      apb(1, `CAM_CTRL_ADDR, 1);
      for (int s = 0; s < 4; s++) begin
         apb(1, `CAM_MODE_ADDR, s << 1);
         apb(1, `CAM_COUNT_ADDR, 0);
         if (s < 2) repeat (24) @(posedge core_clk_i);
         else tick(5, s == 3);
         apb(0, `CAM_COUNT_ADDR, 0);
         d = int'(rd) - span(s);
         check("count", s < 2 ? (d >= -1 && d <= 1) : d == 0, 1);
      end
      $display("source test done");
      apb(1, `CAM_MODE_ADDR, 32'h85);
      apb(1, `CAM_COUNT_ADDR, 32'hFFFE);
      idle_mode_i <= 1;
      tick(3, 0);
      check("run", counter_run_o, 0);
      apb(0, `CAM_COUNT_ADDR, 0);
      check("held", rd, 32'hFFFE);
      idle_mode_i <= 0;
      tick(2, 0);
      check("wrap", count_o, 0);
      check("irq", irq_o, 1);
      apb(1, `CAM_CTRL_ADDR, 1);
      apb(1, `CAM_MODE_ADDR, 32'h04);
      idle_mode_i <= 1;
      apb(1, `CAM_COUNT_ADDR, 32'hFFFF);
      tick(1, 0);
      check("idle run", count_o, 0);
      check("flag", counter_overflow_flag_o, 1);
      check("masked", irq_o, 0);
      $display("halt and irq test done");
      rst_b_i <= 0;
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1;
      @(posedge core_clk_i);
      apb(0, `CAM_MODE_ADDR, 0);
      check("mode", rd & 32'hC7, 0);
      $display("reset test done");
      results();
   end
endmodule // test_counter_array_mode_control
`default_nettype wire
